// File: sfr_cell.sv
/*
  one special function register with a load strobe and an async clear.
  assumes the caller folds any reset-class action into the load strobe and load value.
*/
`timescale 1ns/10ps
module sfr_cell #(
  parameter int WIDTH = 8
) (
  input wire logic pclk, // core clock
  input wire logic presetn, // async reset, active low
  input wire logic clk_en, // freezes state when low
  input wire logic ld, // load strobe
  input wire logic [WIDTH-1:0] ld_val, // value to load
  output logic [WIDTH-1:0] q_ff // register value
);
  if (WIDTH < 1 || WIDTH > 8) begin : g_width_chk
    $error("sfr_cell width out of range");
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_ff <= '0;
    end else if (clk_en && ld) begin
      q_ff <= ld_val;
    end
  end
endmodule // sfr_cell

// File: sfr_reset_pkg.sv
/*
  package for the special function register reset logic: offsets, field positions, reset values.
  assumes an 8-bit register file reached over a 32-bit apb slave, one word per register.
*/
package sfr_reset_pkg;
  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_INDIRECT = 8'h00;
  localparam logic [7:0] IDX_TIMER = 8'h01;
  localparam logic [7:0] IDX_PC_LOW = 8'h02;
  localparam logic [7:0] IDX_STATUS = 8'h03;
  localparam logic [7:0] IDX_POINTER = 8'h04;
  localparam logic [7:0] IDX_PORT_A = 8'h05;
  localparam logic [7:0] IDX_PORT_B = 8'h06;
  localparam logic [7:0] IDX_NV_DATA = 8'h08;
  localparam logic [7:0] IDX_NV_ADDR = 8'h09;
  localparam logic [7:0] IDX_PC_HIGH = 8'h0A;
  localparam logic [7:0] IDX_INTCTL = 8'h0B;
  localparam logic [7:0] IDX_BANK1 = 8'h80;
  localparam logic [7:0] IDX_OPTION = 8'h81;
  localparam logic [7:0] IDX_DIR_A = 8'h85;
  localparam logic [7:0] IDX_DIR_B = 8'h86;
  localparam logic [7:0] IDX_NV_CTL = 8'h88;
  localparam logic [7:0] IDX_NV_UNLOCK = 8'h89;
  localparam logic [7:0] IDX_WORKING = 8'h0C;
  localparam logic [7:0] IDX_WAKE_PC = 8'h0D;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int STATUS_TO_BIT = 4;
  localparam int STATUS_PD_BIT = 3;
  localparam int INTCTL_GIE_BIT = 7;
  localparam int NV_NV_WRITE_ERROR_BIT = 3;

  // ----------------------------------------------------------------
  // reset values and masks
  // ----------------------------------------------------------------
  localparam logic [7:0] PC_LOW_RST = 8'h00;
  localparam logic [7:0] IRQ_VECTOR = 8'h04;
  localparam logic [4:0] PC_HIGH_RST = 5'h00;
  localparam logic [7:0] DIR_B_RST = 8'hFF;
  localparam logic [4:0] DIR_A_RST = 5'h1F;
  localparam logic [7:0] OPTION_RST = 8'hFF;
  localparam logic [7:0] STATUS_POR = 8'h18;
  localparam logic [7:0] STATUS_OTHER_MASK = 8'h1F;
  localparam logic [7:0] INTCTL_OTHER_MASK = 8'h01;
  localparam logic [4:0] NV_CTL_RST = 5'h00;
  localparam logic [7:0] UNDEF_FILL = 8'h00;
  localparam logic [31:0] DATA_ZERO = 32'h0000_0000;
endpackage

// File: sfr_reset_state_logic.sv
/*
  special function register bank with reset-class actions, apb register access.
  assumes reset-class inputs are one-cycle pulses synchronous to pclk, at most one at a time.
*/
`timescale 1ns/10ps
module sfr_reset_state_logic (
  input wire logic pclk, // core clock, 40 MHz
  input wire logic presetn, // async reset, active low
  input wire logic clk_en, // freezes all state when low
  input wire logic por_pulse, // power-on reset class
  input wire logic master_clear_pin_wdt_pulse, // master clear or watchdog reset class
  input wire logic wdt_cause, // with master_clear_pin_wdt_pulse: watchdog caused it
  input wire logic wake_pulse, // wake-up from halt
  input wire logic wake_by_wdt, // with wake_pulse: watchdog time-out
  input wire logic [7:0] wake_flags, // interrupt flags that caused wake-up
  input wire logic nv_err_cond, // write error condition at reset
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  output logic [7:0] pc_low_ff, // program counter low byte
  output logic [4:0] dir_a_ff, // port a direction
  output logic [7:0] dir_b_ff // port b direction
);
  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic acc;
  logic wr;
  logic [7:0] idx;
  logic hit;
  logic [7:0] wd;

  function automatic logic mapped(input logic [7:0] i);
    unique case (i)
      sfr_reset_pkg::IDX_INDIRECT, sfr_reset_pkg::IDX_TIMER, sfr_reset_pkg::IDX_PC_LOW,
      sfr_reset_pkg::IDX_STATUS, sfr_reset_pkg::IDX_POINTER, sfr_reset_pkg::IDX_PORT_A,
      sfr_reset_pkg::IDX_PORT_B, sfr_reset_pkg::IDX_NV_DATA, sfr_reset_pkg::IDX_NV_ADDR,
      sfr_reset_pkg::IDX_PC_HIGH, sfr_reset_pkg::IDX_INTCTL, sfr_reset_pkg::IDX_WORKING,
      sfr_reset_pkg::IDX_WAKE_PC, sfr_reset_pkg::IDX_BANK1, sfr_reset_pkg::IDX_OPTION,
      sfr_reset_pkg::IDX_DIR_A, sfr_reset_pkg::IDX_DIR_B, sfr_reset_pkg::IDX_NV_CTL,
      sfr_reset_pkg::IDX_NV_UNLOCK, (sfr_reset_pkg::IDX_PC_LOW | sfr_reset_pkg::IDX_BANK1),
      (sfr_reset_pkg::IDX_STATUS | sfr_reset_pkg::IDX_BANK1),
      (sfr_reset_pkg::IDX_POINTER | sfr_reset_pkg::IDX_BANK1),
      (sfr_reset_pkg::IDX_PC_HIGH | sfr_reset_pkg::IDX_BANK1),
      (sfr_reset_pkg::IDX_INTCTL | sfr_reset_pkg::IDX_BANK1): mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  endfunction

  // mirrored bank 1 registers fold onto bank 0
  function automatic logic [7:0] fold(input logic [7:0] i);
    unique case (i)
      (sfr_reset_pkg::IDX_PC_LOW | sfr_reset_pkg::IDX_BANK1),
      (sfr_reset_pkg::IDX_STATUS | sfr_reset_pkg::IDX_BANK1),
      (sfr_reset_pkg::IDX_POINTER | sfr_reset_pkg::IDX_BANK1),
      (sfr_reset_pkg::IDX_PC_HIGH | sfr_reset_pkg::IDX_BANK1),
      (sfr_reset_pkg::IDX_INTCTL | sfr_reset_pkg::IDX_BANK1): fold = i & 8'h7F;
      default: fold = i;
    endcase
  endfunction

  // write taken once, at the first access edge only
  assign acc = psel && penable && clk_en && !pready;
  assign idx = fold(paddr[9:2]);
  assign hit = mapped(paddr[9:2]) && (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0);
  // writes go nowhere while a reset class is active
  assign wr = acc && pwrite && hit && !(por_pulse || master_clear_pin_wdt_pulse || wake_pulse);
  assign wd = pwdata[7:0];

  function automatic logic wsel(input logic [7:0] i);
    wsel = wr && (idx == i);
  endfunction

  // ----------------------------------------------------------------
  // retained data registers
  // ----------------------------------------------------------------
  logic [7:0] timer_ff;
  logic [7:0] pointer_ff;
  logic [7:0] working_ff;
  logic [7:0] nv_data_ff;
  logic [7:0] nv_addr_ff;
  logic [4:0] port_a_ff;
  logic [7:0] port_b_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_ff <= sfr_reset_pkg::UNDEF_FILL;
      pointer_ff <= sfr_reset_pkg::UNDEF_FILL;
      working_ff <= sfr_reset_pkg::UNDEF_FILL;
      nv_data_ff <= sfr_reset_pkg::UNDEF_FILL;
      nv_addr_ff <= sfr_reset_pkg::UNDEF_FILL;
    end else if (clk_en) begin
      if (wsel(sfr_reset_pkg::IDX_TIMER)) timer_ff <= wd;
      if (wsel(sfr_reset_pkg::IDX_POINTER)) pointer_ff <= wd;
      if (wsel(sfr_reset_pkg::IDX_WORKING)) working_ff <= wd;
      if (wsel(sfr_reset_pkg::IDX_NV_DATA)) nv_data_ff <= wd;
      if (wsel(sfr_reset_pkg::IDX_NV_ADDR)) nv_addr_ff <= wd;
    end
  end

  // port latches keep after every reset class, power-on included; only presetn clears them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_a_ff <= '0;
      port_b_ff <= sfr_reset_pkg::UNDEF_FILL;
    end else if (clk_en) begin
      if (wsel(sfr_reset_pkg::IDX_PORT_A)) port_a_ff <= wd[4:0];
      if (wsel(sfr_reset_pkg::IDX_PORT_B)) port_b_ff <= wd;
    end
  end

  // ----------------------------------------------------------------
  // program counter
  // ----------------------------------------------------------------
  logic [7:0] wake_pc_ff;
  logic [7:0] intctl_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_pc_ff <= sfr_reset_pkg::PC_LOW_RST;
    end else if (clk_en && wsel(sfr_reset_pkg::IDX_WAKE_PC)) begin
      wake_pc_ff <= wd;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_low_ff <= sfr_reset_pkg::PC_LOW_RST;
    end else if (clk_en) begin
      if (por_pulse || master_clear_pin_wdt_pulse) begin
        pc_low_ff <= sfr_reset_pkg::PC_LOW_RST;
      end else if (wake_pulse) begin
        if (!wake_by_wdt && intctl_ff[sfr_reset_pkg::INTCTL_GIE_BIT]) begin
          pc_low_ff <= sfr_reset_pkg::IRQ_VECTOR;
        end else begin
          pc_low_ff <= 8'(wake_pc_ff + 8'h01);
        end
      end else if (wsel(sfr_reset_pkg::IDX_PC_LOW)) begin
        pc_low_ff <= wd;
      end
    end
  end

  // ----------------------------------------------------------------
  // pc high latch and option (via cell module), direction
  // ----------------------------------------------------------------
  logic [4:0] pc_high_q;
  logic [7:0] option_q;
  logic hard_rst;
  assign hard_rst = por_pulse || master_clear_pin_wdt_pulse;

  // pc high cleared on hard reset, kept on wake
  sfr_cell #(.WIDTH(5)) u_pc_high (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .ld(hard_rst || wsel(sfr_reset_pkg::IDX_PC_HIGH)),
    .ld_val(hard_rst ? sfr_reset_pkg::PC_HIGH_RST : wd[4:0]),
    .q_ff(pc_high_q)
  );

  // option all ones on hard reset
  logic [7:0] option_raw;
  sfr_cell #(.WIDTH(8)) u_option (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .ld(hard_rst || wsel(sfr_reset_pkg::IDX_OPTION)),
    .ld_val(hard_rst ? 8'h00 : ~wd),
    .q_ff(option_raw)
  );
  // stored inverted so the async reset value reads as all ones
  assign option_q = option_raw ^ sfr_reset_pkg::OPTION_RST;

  // directions all ones on power-on and master clear or watchdog reset, kept on wake
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_a_ff <= sfr_reset_pkg::DIR_A_RST;
      dir_b_ff <= sfr_reset_pkg::DIR_B_RST;
    end else if (clk_en) begin
      if (hard_rst) begin
        dir_a_ff <= sfr_reset_pkg::DIR_A_RST;
        dir_b_ff <= sfr_reset_pkg::DIR_B_RST;
      end else begin
        if (wsel(sfr_reset_pkg::IDX_DIR_A)) dir_a_ff <= wd[4:0];
        if (wsel(sfr_reset_pkg::IDX_DIR_B)) dir_b_ff <= wd;
      end
    end
  end

  // ----------------------------------------------------------------
  // interrupt control, status, nv control
  // ----------------------------------------------------------------
  logic [7:0] status_ff;
  logic [4:0] nv_ctl_ff;

  // one register serves both bank addresses
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      intctl_ff <= 8'h00;
    end else if (clk_en) begin
      if (por_pulse) begin
        intctl_ff <= 8'h00;
      end else if (master_clear_pin_wdt_pulse) begin
        intctl_ff <= intctl_ff & sfr_reset_pkg::INTCTL_OTHER_MASK;
      end else if (wake_pulse) begin
        intctl_ff <= intctl_ff | wake_flags;
      end else if (wsel(sfr_reset_pkg::IDX_INTCTL)) begin
        intctl_ff <= wd;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_ff <= sfr_reset_pkg::STATUS_POR;
    end else if (clk_en) begin
      if (por_pulse) begin
        status_ff <= sfr_reset_pkg::STATUS_POR;
      end else if (master_clear_pin_wdt_pulse) begin
        status_ff <= status_ff & sfr_reset_pkg::STATUS_OTHER_MASK;
        if (wdt_cause) begin
          status_ff[sfr_reset_pkg::STATUS_TO_BIT] <= 1'b0;
          status_ff[sfr_reset_pkg::STATUS_PD_BIT] <= 1'b1;
        end
      end else if (wake_pulse) begin
        status_ff[sfr_reset_pkg::STATUS_TO_BIT] <= !wake_by_wdt;
        status_ff[sfr_reset_pkg::STATUS_PD_BIT] <= 1'b0;
      end else if (wsel(sfr_reset_pkg::IDX_STATUS)) begin
        // cause bits are read-only to software
        status_ff <= {wd[7:5], status_ff[4:3], wd[2:0]};
      end
    end
  end

  // nv control clears on hard reset, error bit by condition on master clear or watchdog reset, kept on wake
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nv_ctl_ff <= sfr_reset_pkg::NV_CTL_RST;
    end else if (clk_en) begin
      if (por_pulse) begin
        nv_ctl_ff <= sfr_reset_pkg::NV_CTL_RST;
      end else if (master_clear_pin_wdt_pulse) begin
        nv_ctl_ff <= sfr_reset_pkg::NV_CTL_RST;
        nv_ctl_ff[sfr_reset_pkg::NV_NV_WRITE_ERROR_BIT] <= nv_err_cond;
      end else if (wsel(sfr_reset_pkg::IDX_NV_CTL)) begin
        nv_ctl_ff <= wd[4:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // read mux and apb answer
  // ----------------------------------------------------------------
  logic [7:0] rd;
  always_comb begin
    rd = 8'h00;
    // unimplemented bits and locations read zero
    unique case (idx)
      sfr_reset_pkg::IDX_TIMER: rd = timer_ff;
      sfr_reset_pkg::IDX_PC_LOW: rd = pc_low_ff;
      sfr_reset_pkg::IDX_STATUS: rd = status_ff;
      sfr_reset_pkg::IDX_POINTER: rd = pointer_ff;
      sfr_reset_pkg::IDX_PORT_A: rd = {3'h0, port_a_ff};
      sfr_reset_pkg::IDX_PORT_B: rd = port_b_ff;
      sfr_reset_pkg::IDX_NV_DATA: rd = nv_data_ff;
      sfr_reset_pkg::IDX_NV_ADDR: rd = nv_addr_ff;
      sfr_reset_pkg::IDX_PC_HIGH: rd = {3'h0, pc_high_q};
      sfr_reset_pkg::IDX_INTCTL: rd = intctl_ff;
      sfr_reset_pkg::IDX_WORKING: rd = working_ff;
      sfr_reset_pkg::IDX_WAKE_PC: rd = wake_pc_ff;
      sfr_reset_pkg::IDX_OPTION: rd = option_q;
      sfr_reset_pkg::IDX_DIR_A: rd = {3'h0, dir_a_ff};
      sfr_reset_pkg::IDX_DIR_B: rd = dir_b_ff;
      sfr_reset_pkg::IDX_NV_CTL: rd = {3'h0, nv_ctl_ff};
      default: rd = 8'h00;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= sfr_reset_pkg::DATA_ZERO;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !hit;
      prdata <= (psel && penable && !pready && hit && !pwrite) ? {24'h0, rd} : sfr_reset_pkg::DATA_ZERO;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_hard_pc_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && (por_pulse || master_clear_pin_wdt_pulse)) |=> pc_low_ff == sfr_reset_pkg::PC_LOW_RST)
    else $error("pc low not cleared");
  a_wake_vector: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && wake_pulse && !por_pulse && !master_clear_pin_wdt_pulse && !wake_by_wdt && intctl_ff[7])
    |=> pc_low_ff == sfr_reset_pkg::IRQ_VECTOR)
    else $error("vector not loaded");
  a_pc_high_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && hard_rst) |=> pc_high_q == sfr_reset_pkg::PC_HIGH_RST)
    else $error("pc high not cleared");
  a_dir_ones: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && hard_rst) |=> (dir_b_ff == sfr_reset_pkg::DIR_B_RST && dir_a_ff == sfr_reset_pkg::DIR_A_RST))
    else $error("direction not all ones");
  a_option_ones: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && hard_rst) |=> option_q == sfr_reset_pkg::OPTION_RST)
    else $error("option not all ones");
  a_master_clear_pin_keeps_cause: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && master_clear_pin_wdt_pulse && !por_pulse && !wdt_cause) |=> $stable(status_ff[4:3]))
    else $error("cause bits changed on master clear");
  a_intctl_bit0: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && master_clear_pin_wdt_pulse && !por_pulse) |=> (intctl_ff[7:1] == 7'h00 && intctl_ff[0] == $past(intctl_ff[0])))
    else $error("interrupt control wrong after reset");
  a_retain_data: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && (master_clear_pin_wdt_pulse || wake_pulse)) |=> $stable(nv_data_ff) && $stable(nv_addr_ff))
    else $error("nv data lost on reset");
  a_apb_ready: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && psel && penable && !pready) |=> pready)
    else $error("apb answer late");
endmodule // sfr_reset_state_logic

// File: sfr_reset_state_logic_test.sv
/*
  self-checking testbench for the register bank with reset-class actions.
  assumes the apb slave answers in its own time and unknown reset values read as zero.
*/
`timescale 1ns/10ps
module sfr_reset_state_logic_test;
  logic pclk, presetn, clk_en, por_pulse, master_clear_pin_wdt_pulse, wdt_cause, wake_pulse, wake_by_wdt;
  logic nv_err_cond, psel, penable, pwrite, pready, pslverr;
  logic [7:0] wake_flags, pc_low_ff, dir_b_ff;
  logic [4:0] dir_a_ff;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  int mismatches, n_tests;

  sfr_reset_state_logic sfr_reset_state_logic_i (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
    .por_pulse(por_pulse), .master_clear_pin_wdt_pulse(master_clear_pin_wdt_pulse), .wdt_cause(wdt_cause), .wake_pulse(wake_pulse),
    .wake_by_wdt(wake_by_wdt), .wake_flags(wake_flags), .nv_err_cond(nv_err_cond), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pc_low_ff(pc_low_ff), .dir_a_ff(dir_a_ff), .dir_b_ff(dir_b_ff));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
      mismatches++;
    end
  endtask

  // one transfer; request held until pready is sampled high at a rising edge, released right after
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) chk("pready", 32'h1, 32'h0);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
    logic [31:0] rd;
    logic err;
    apb(1'b1, idx, wd, rd, err);
  endtask

  task automatic rd_chk(input string name, input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] rd;
    logic err;
    apb(1'b0, idx, 32'h0000_0000, rd, err);
    chk(name, exp, rd);
  endtask

  // one-cycle pulse of a reset class: 0 power-on, 1 master clear or watchdog, 2 wake
  task automatic fire(input logic [1:0] cls);
    @(posedge pclk);
    por_pulse <= (cls == 2'h0);
    master_clear_pin_wdt_pulse <= (cls == 2'h1);
    wake_pulse <= (cls == 2'h2);
    @(posedge pclk);
    por_pulse <= 1'b0;
    master_clear_pin_wdt_pulse <= 1'b0;
    wake_pulse <= 1'b0;
    @(negedge pclk);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic chk_por();
    chk("pc_low_port", 32'(sfr_reset_pkg::PC_LOW_RST), 32'(pc_low_ff));
    chk("dir_a_port", 32'(sfr_reset_pkg::DIR_A_RST), 32'(dir_a_ff));
    chk("dir_b_port", 32'(sfr_reset_pkg::DIR_B_RST), 32'(dir_b_ff));
    rd_chk("pc_low", sfr_reset_pkg::IDX_PC_LOW, 32'h0000_0000);
    rd_chk("status", sfr_reset_pkg::IDX_STATUS, 32'(sfr_reset_pkg::STATUS_POR));
    rd_chk("option", sfr_reset_pkg::IDX_OPTION, 32'h0000_00FF);
    rd_chk("dir_a", sfr_reset_pkg::IDX_DIR_A, 32'h0000_001F);
    rd_chk("pc_high", sfr_reset_pkg::IDX_PC_HIGH, 32'h0000_0000);
    rd_chk("intctl", sfr_reset_pkg::IDX_INTCTL, 32'h0000_0000);
    rd_chk("nv_ctl", sfr_reset_pkg::IDX_NV_CTL, 32'h0000_0000);
  endtask

  task automatic t_watchdog_reset();
    wr(sfr_reset_pkg::IDX_TIMER, 32'h0000_0011);
    wr(sfr_reset_pkg::IDX_POINTER, 32'h0000_0022);
    wr(sfr_reset_pkg::IDX_PORT_A, 32'h0000_0015);
    wr(sfr_reset_pkg::IDX_PORT_B, 32'h0000_0033);
    wr(sfr_reset_pkg::IDX_NV_DATA, 32'h0000_0044);
    wr(sfr_reset_pkg::IDX_NV_ADDR, 32'h0000_0055);
    wr(sfr_reset_pkg::IDX_WORKING, 32'h0000_0066);
    wr(sfr_reset_pkg::IDX_PC_HIGH, 32'h0000_001A);
    wr(sfr_reset_pkg::IDX_OPTION, 32'h0000_005A);
    wr(sfr_reset_pkg::IDX_DIR_A, 32'h0000_000A);
    wr(sfr_reset_pkg::IDX_DIR_B, 32'h0000_003C);
    wr(sfr_reset_pkg::IDX_INTCTL, 32'h0000_00A5);
    wr(sfr_reset_pkg::IDX_PC_LOW, 32'h0000_0077);
    wr(sfr_reset_pkg::IDX_STATUS, 32'h0000_00E7);
    rd_chk("status_wr", sfr_reset_pkg::IDX_STATUS, 32'h0000_00FF);
    wdt_cause <= 1'b1;
    nv_err_cond <= 1'b1;
    fire(2'h1);
    chk("pc_low_port", 32'h0000_0000, 32'(pc_low_ff));
    chk("dir_b_port", 32'h0000_00FF, 32'(dir_b_ff));
    rd_chk("pc_high", sfr_reset_pkg::IDX_PC_HIGH, 32'h0000_0000);
    rd_chk("dir_a", sfr_reset_pkg::IDX_DIR_A, 32'h0000_001F);
    rd_chk("option", sfr_reset_pkg::IDX_OPTION, 32'h0000_00FF);
    rd_chk("intctl", sfr_reset_pkg::IDX_INTCTL, 32'h0000_0001);
    rd_chk("status", sfr_reset_pkg::IDX_STATUS, 32'h0000_000F);
    rd_chk("nv_ctl", sfr_reset_pkg::IDX_NV_CTL, 32'h0000_0008);
    rd_chk("port_a", sfr_reset_pkg::IDX_PORT_A, 32'h0000_0015);
    rd_chk("port_b", sfr_reset_pkg::IDX_PORT_B, 32'h0000_0033);
    rd_chk("nv_data", sfr_reset_pkg::IDX_NV_DATA, 32'h0000_0044);
    rd_chk("nv_addr", sfr_reset_pkg::IDX_NV_ADDR, 32'h0000_0055);
    rd_chk("timer", sfr_reset_pkg::IDX_TIMER, 32'h0000_0011);
    rd_chk("pointer", sfr_reset_pkg::IDX_POINTER, 32'h0000_0022);
    rd_chk("working", sfr_reset_pkg::IDX_WORKING, 32'h0000_0066);
  endtask

  task automatic t_wake();
    wr(sfr_reset_pkg::IDX_INTCTL, 32'h0000_0080);
    wr(sfr_reset_pkg::IDX_WAKE_PC, 32'h0000_003C);
    wr(sfr_reset_pkg::IDX_PC_HIGH, 32'h0000_000B);
    wr(sfr_reset_pkg::IDX_DIR_B, 32'h0000_005A);
    wr(sfr_reset_pkg::IDX_OPTION, 32'h0000_003C);
    wake_by_wdt <= 1'b0;
    wake_flags <= 8'h02;
    fire(2'h2);
    chk("pc_low_vector", 32'h0000_0004, 32'(pc_low_ff));
    chk("dir_b_port", 32'h0000_005A, 32'(dir_b_ff));
    rd_chk("intctl", sfr_reset_pkg::IDX_INTCTL, 32'h0000_0082);
    rd_chk("status", sfr_reset_pkg::IDX_STATUS, 32'h0000_0017);
    rd_chk("pc_high", sfr_reset_pkg::IDX_PC_HIGH, 32'h0000_000B);
    rd_chk("option", sfr_reset_pkg::IDX_OPTION, 32'h0000_003C);
    rd_chk("nv_ctl", sfr_reset_pkg::IDX_NV_CTL, 32'h0000_0008);
    rd_chk("port_b", sfr_reset_pkg::IDX_PORT_B, 32'h0000_0033);
    // watchdog wake with enable still set: next address, not the vector
    wake_by_wdt <= 1'b1;
    wake_flags <= 8'h00;
    fire(2'h2);
    chk("pc_low_next", 32'h0000_003D, 32'(pc_low_ff));
    rd_chk("status", sfr_reset_pkg::IDX_STATUS, 32'h0000_0007);
    wdt_cause <= 1'b0;
    nv_err_cond <= 1'b0;
    fire(2'h1);
    rd_chk("status_master_clear_pin", sfr_reset_pkg::IDX_STATUS, 32'h0000_0007);
    rd_chk("intctl", sfr_reset_pkg::IDX_INTCTL, 32'h0000_0000);
    rd_chk("nv_ctl", sfr_reset_pkg::IDX_NV_CTL, 32'h0000_0000);
  endtask

  task automatic t_bus();
    logic [31:0] rd;
    logic err;
    wr(sfr_reset_pkg::IDX_BANK1 | sfr_reset_pkg::IDX_INTCTL, 32'h0000_0055);
    rd_chk("intctl_mirror", sfr_reset_pkg::IDX_INTCTL, 32'h0000_0055);
    wr(sfr_reset_pkg::IDX_PC_HIGH, 32'hFFFF_FFFF);
    rd_chk("pc_high_mirror", sfr_reset_pkg::IDX_BANK1 | sfr_reset_pkg::IDX_PC_HIGH, 32'h0000_001F);
    wr(sfr_reset_pkg::IDX_DIR_A, 32'hFFFF_FFFF);
    rd_chk("dir_a", sfr_reset_pkg::IDX_DIR_A, 32'h0000_001F);
    apb(1'b1, 8'h87, 32'h0000_00FF, rd, err);
    chk("unmapped_err", 32'h0000_0001, 32'(err));
    wr(sfr_reset_pkg::IDX_DIR_B, 32'h0000_0000);
    wr(sfr_reset_pkg::IDX_STATUS, 32'h0000_0000);
    // clock enable low: a reset class must not touch state
    clk_en <= 1'b0;
    fire(2'h1);
    chk("dir_b_frozen", 32'h0000_0000, 32'(dir_b_ff));
    clk_en <= 1'b1;
    fire(2'h0);
    chk_por();
  endtask

  task automatic test_done();
    $display("comparisons %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // clock, reset, sequence, watchdog
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  initial begin
    {presetn, por_pulse, master_clear_pin_wdt_pulse, wdt_cause, wake_pulse, wake_by_wdt} = 6'h00;
    {nv_err_cond, psel, penable, pwrite} = 4'h0;
    clk_en = 1'b1;
    wake_flags = 8'h00;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    mismatches = 0;
    n_tests = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk_por();
    t_watchdog_reset();
    t_wake();
    t_bus();
    test_done();
  end

  initial begin
    repeat (3000) @(posedge pclk);
    mismatches++;
    test_done();
  end
endmodule // sfr_reset_state_logic_test
